// ===== hdl/pmg_regs.svh
// Register indices, field positions and reset values of the port-4 pin mux.
// Assumes the includer adds the AXI4-Lite byte address as four times an index.
`ifndef PMG_REGS_SVH
`define PMG_REGS_SVH

`define PMG_IDX_DIR        16'hFFB5
`define PMG_IDX_DATA       16'hFFB7
`define PMG_IDX_CTRL       16'hFFB0
`define PMG_IDX_STAT       16'hFFB1

`define PMG_DIR_RST_EXP    8'h40
`define PMG_DIR_RST_SGL    8'h00
`define PMG_DATA_RST       8'h00
`define PMG_DIR_READ       8'hFF
`define PMG_CTRL_RST       19'h00000
`define PMG_CLK_PIN        6

`define PMG_CTRL_HIE       0
`define PMG_CTRL_GA20E     1
`define PMG_CTRL_SYNC_ENABLE     2
`define PMG_CTRL_SWSTBY    3
`define PMG_CTRL_TXOS_LO   4
`define PMG_CTRL_T1OS_LO   8
`define PMG_CTRL_T1CCLR_LO 12
`define PMG_CTRL_T1CKS_LO  14
`define PMG_CTRL_T0CCLR_LO 17

`define PMG_MODE_SGL       2'h3
`define PMG_CKS_EXT_MIN    3'h5
`define PMG_CCLR_EXT       2'h3
`define PMG_RESP_OKAY      2'h0
`define PMG_RESP_SLVERR    2'h2

`endif

// ===== hdl/pmg_pkg.sv
// Types shared by the port-4 pin mux.
// Assumes pmg_regs.svh holds the numeric constants.
package pmg_pkg;

  typedef logic [1:0] pmg_mode_t;

  // Peripheral signals that drive pins
  typedef struct packed {
    logic timer_x_out;
    logic timer1_out;
    logic clamp_out;
    logic hsync_out;
    logic gate_a20_out;
    logic host_irq_one;
    logic host_irq_eleven;
    logic host_irq_twelve;
    logic clock_out;
  } pmg_periph_out_t;

  // Pin levels handed to peripherals
  typedef struct packed {
    logic timer1_reset_in;
    logic composite_sync_in;
    logic timer1_ext_clock_in;
    logic hsync_in;
    logic field_feedback_in;
    logic timer0_reset_in;
    logic host_chip_select_n;
  } pmg_periph_in_t;

endpackage : pmg_pkg

// ===== hdl/pmg_port4.sv
// Port-4 GPIO with per-pin function mux and an AXI4-Lite register slave.
// Assumes pins and mode straps are asynchronous; peripherals share sys_clk.
`timescale 1ns/1ps
`include "pmg_regs.svh"

module pmg_port4 #(
  parameter int ADDR_W = 18
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [1:0]            mode_pins,
  input  wire logic                  hw_standby,
  input  wire pmg_pkg::pmg_periph_out_t periph_out,
  output      pmg_pkg::pmg_periph_in_t  periph_in,
  input  wire logic [7:0]            pin_in,
  output      logic [7:0]            pin_out,
  output      logic [7:0]            pin_oe_n
);
  import pmg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [7:0]  pin_meta_q;
  logic [7:0]  pin_q;
  logic [1:0]  mode_meta_q;
  logic [1:0]  mode_sync_q;
  logic        stby_meta_q;
  logic        stby_q;

  always_ff @(posedge sys_clk) begin
    pin_meta_q  <= pin_in;
    pin_q       <= pin_meta_q;
    mode_meta_q <= mode_pins;
    mode_sync_q <= mode_meta_q;
    stby_meta_q <= hw_standby;
    stby_q      <= stby_meta_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode strap, caught while reset is held

  pmg_mode_t mode_q;
  logic      init_now;
  logic      expanded;
  logic      slave;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q <= mode_sync_q;
    end
  end

  assign init_now = reset || stby_q;
  assign expanded = (mode_q != `PMG_MODE_SGL);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels

  logic              awready_q;
  logic              wready_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic              w_lane0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_fire;
  logic [15:0]       wr_idx;
  logic              wr_en;
  logic              wr_known;

  assign wr_fire  = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx   = aw_addr_q[ADDR_W-1:2];
  assign wr_en    = wr_fire && w_lane0_q;
  assign wr_known = (wr_idx == `PMG_IDX_DIR) || (wr_idx == `PMG_IDX_DATA) ||
                    (wr_idx == `PMG_IDX_CTRL) || (wr_idx == `PMG_IDX_STAT);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h00000000;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PMG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_held_q  <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
        wready_q  <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_known ? `PMG_RESP_OKAY : `PMG_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction register

  logic [7:0] dir_q;
  logic [7:0] dir_wr;

  always_comb begin
    dir_wr = w_data_q[7:0];
    if (expanded) begin
      dir_wr[`PMG_CLK_PIN] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (init_now) begin
      dir_q <= (reset ? (mode_sync_q != `PMG_MODE_SGL) : expanded) ?
               `PMG_DIR_RST_EXP : `PMG_DIR_RST_SGL;
    end else if (wr_en && wr_idx == `PMG_IDX_DIR) begin
      dir_q <= dir_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data register

  logic [7:0] data_q;

  always_ff @(posedge sys_clk) begin
    if (init_now) begin
      data_q <= `PMG_DATA_RST;
    end else if (wr_en && wr_idx == `PMG_IDX_DATA) begin
      data_q <= {w_data_q[7], 1'b0, w_data_q[5:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [18:0] ctrl_q;
  logic [18:0] ctrl_wr;
  logic        sw_stby;

  assign sw_stby = ctrl_q[`PMG_CTRL_SWSTBY];

  always_comb begin
    ctrl_wr = w_data_q[18:0];
    if (ctrl_wr[`PMG_CTRL_SWSTBY]) begin
      ctrl_wr[`PMG_CTRL_SYNC_ENABLE]              = 1'b0;
      ctrl_wr[`PMG_CTRL_T1OS_LO+3 -: 8]     = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (init_now) begin
      ctrl_q <= `PMG_CTRL_RST;
    end else if (wr_en && wr_idx == `PMG_IDX_CTRL) begin
      ctrl_q <= ctrl_wr;
    end else if (sw_stby) begin
      ctrl_q[`PMG_CTRL_SYNC_ENABLE]          <= 1'b0;
      ctrl_q[`PMG_CTRL_T1OS_LO+3 -: 8] <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function selects

  logic       sync_en;
  logic       gate_a20_out_en;
  logic [3:0] tx_os;
  logic [3:0] t1_os;
  logic [1:0] t1_cclr;
  logic [2:0] t1_cks;
  logic [1:0] t0_cclr;

  assign sync_en = ctrl_q[`PMG_CTRL_SYNC_ENABLE];
  assign gate_a20_out_en = ctrl_q[`PMG_CTRL_GA20E];
  assign tx_os   = ctrl_q[`PMG_CTRL_TXOS_LO+:4];
  assign t1_os   = ctrl_q[`PMG_CTRL_T1OS_LO+:4];
  assign t1_cclr = ctrl_q[`PMG_CTRL_T1CCLR_LO+:2];
  assign t1_cks  = ctrl_q[`PMG_CTRL_T1CKS_LO+:3];
  assign t0_cclr = ctrl_q[`PMG_CTRL_T0CCLR_LO+:2];
  assign slave   = !expanded && ctrl_q[`PMG_CTRL_HIE];

  ////////////////////////////////////////////////////////////////////////////
  // Pin mux

  logic [7:0]     out_d;
  logic [7:0]     drv_d;
  pmg_periph_in_t pin_fn_d;

  always_comb begin
    out_d = data_q;
    drv_d = dir_q;
    if (sync_en) begin
      out_d[7] = periph_out.clamp_out;
      drv_d[7] = 1'b1;
    end else if (tx_os != 4'h0) begin
      out_d[7] = periph_out.timer_x_out;
      drv_d[7] = 1'b1;
    end else if (gate_a20_out_en && slave) begin
      out_d[7] = periph_out.gate_a20_out;
    end
    out_d[6] = periph_out.clock_out;
    if (expanded) begin
      drv_d[6] = 1'b1;
    end else if (slave) begin
      drv_d[6] = 1'b0;
    end
    if (slave) begin
      out_d[5] = periph_out.host_irq_twelve;
    end
    if (sync_en) begin
      out_d[4] = periph_out.hsync_out;
      drv_d[4] = 1'b1;
    end else if (t1_os != 4'h0) begin
      out_d[4] = periph_out.timer1_out;
      drv_d[4] = 1'b1;
    end else if (slave) begin
      out_d[4] = periph_out.host_irq_one;
    end
    if (slave) begin
      out_d[3] = periph_out.host_irq_eleven;
    end
  end

  always_comb begin
    pin_fn_d.timer1_reset_in     = (t1_cclr == `PMG_CCLR_EXT) && !dir_q[5] &&
                                   pin_q[5];
    pin_fn_d.composite_sync_in   = !dir_q[5] && pin_q[5];
    pin_fn_d.timer1_ext_clock_in = (t1_cks >= `PMG_CKS_EXT_MIN) && !dir_q[3] &&
                                   pin_q[3];
    pin_fn_d.hsync_in            = !dir_q[3] && pin_q[3];
    pin_fn_d.field_feedback_in   = !expanded && !slave && !dir_q[6] &&
                                   pin_q[6];
    pin_fn_d.timer0_reset_in     = (t0_cclr == `PMG_CCLR_EXT) && !dir_q[2] &&
                                   pin_q[2];
    pin_fn_d.host_chip_select_n  = slave ? pin_q[6] : 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_out   <= 8'h00;
      pin_oe_n  <= 8'hFF;
      periph_in <= '{default: 1'b0, host_chip_select_n: 1'b1};
    end else begin
      pin_out   <= out_d;
      pin_oe_n  <= ~drv_d;
      periph_in <= pin_fn_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [15:0] rd_idx;
  logic [31:0] rd_data_d;
  logic [1:0]  rd_resp_d;
  logic [7:0]  data_view;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    data_view = (dir_q & data_q) | (~dir_q & pin_q);
    data_view[`PMG_CLK_PIN] = pin_q[`PMG_CLK_PIN];
    rd_resp_d = `PMG_RESP_OKAY;
    case (rd_idx)
      `PMG_IDX_DIR:  rd_data_d = {24'h000000, `PMG_DIR_READ};
      `PMG_IDX_DATA: rd_data_d = {24'h000000, data_view};
      `PMG_IDX_CTRL: rd_data_d = {13'h0000, ctrl_q};
      `PMG_IDX_STAT: rd_data_d = {16'h0000, pin_q, 4'h0, stby_q, slave, mode_q};
      default: begin
        rd_data_d = 32'h00000000;
        rd_resp_d = `PMG_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `PMG_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data_d;
      rresp_q   <= rd_resp_d;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule : pmg_port4

// ===== testbench/pmg_port4_properties.sv
// Concurrent checks on the port-4 pin mux ports.
// Assumes mode_pins stay steady while reset is high.
`timescale 1ns/1ps
`include "pmg_regs.svh"
module pmg_port4_properties #(
  parameter int ADDR_W = 18
) (
  input wire logic                     sys_clk,
  input wire logic                     reset,
  input wire logic [ADDR_W-1:0]        s_axi_araddr,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic [1:0]               mode_pins,
  input wire logic                     hw_standby,
  input wire pmg_pkg::pmg_periph_out_t periph_out,
  input wire pmg_pkg::pmg_periph_in_t  periph_in,
  input wire logic [7:0]               pin_in,
  input wire logic [7:0]               pin_out,
  input wire logic [7:0]               pin_oe_n
);
  import pmg_pkg::*;
  localparam logic [ADDR_W-1:0] DIR_A = {`PMG_IDX_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] DAT_A = {`PMG_IDX_DATA, 2'h0};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [1:0] mode_q;
  logic [1:0] same6_q;
  logic       prev6_q;
  logic       ar_hit;
  assign ar_hit = s_axi_arvalid && s_axi_arready;
  ////////////////////////////////////////
  // Mode strap seen during reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q <= mode_pins;
    end
  end
  // Cycles that pin 6 has held still
  always_ff @(posedge sys_clk) begin
    prev6_q <= pin_in[6];
    if (reset || pin_in[6] != prev6_q) begin
      same6_q <= 2'h0;
    end else if (same6_q != 2'h3) begin
      same6_q <= same6_q + 2'h1;
    end
  end
  ////////////////////////////////////////
  a_dir_reads_ones: assert property (
    ar_hit && s_axi_araddr == DIR_A |=> s_axi_rdata == 32'h000000FF)
    else $error("direction read not all ones");
  a_bit6_live: assert property (
    ar_hit && s_axi_araddr == DAT_A && same6_q == 2'h3
    |=> s_axi_rdata[6] == $past(prev6_q))
    else $error("data bit 6 not the pin level");
  a_clk_pin_out: assert property (
    mode_q != 2'h3 && !$past(reset)
    |-> !pin_oe_n[6] && pin_out[6] == $past(periph_out.clock_out))
    else $error("clock pin not driven in expanded mode");
  a_reset_oe: assert property (
    $fell(reset) |-> ##1 pin_oe_n == (mode_q == 2'h3 ? 8'hFF : 8'hBF))
    else $error("pin drive wrong after reset");
  a_hwstby_oe: assert property (
    (mode_q == 2'h3 && hw_standby) [*5] |=> pin_oe_n == 8'hFF)
    else $error("pin drive wrong in hardware standby");
  a_no_slave_cs: assert property (
    mode_q != 2'h3 |-> periph_in.host_chip_select_n)
    else $error("chip select active outside single-chip mode");
  a_pin2_gate: assert property (
    !pin_oe_n[2] |-> !periph_in.timer0_reset_in)
    else $error("timer 0 reset fed from an output pin");
  a_pin3_gate: assert property (
    !pin_oe_n[3] |-> !periph_in.timer1_ext_clock_in && !periph_in.hsync_in)
    else $error("pin 3 inputs fed from an output pin");
  a_pin5_gate: assert property (
    !pin_oe_n[5] |-> !periph_in.timer1_reset_in && !periph_in.composite_sync_in)
    else $error("pin 5 inputs fed from an output pin");
endmodule : pmg_port4_properties

bind pmg_port4 pmg_port4_properties #(.ADDR_W(ADDR_W)) props_u (
  .sys_clk, .reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .mode_pins, .hw_standby, .periph_out, .periph_in, .pin_in, .pin_out, .pin_oe_n
);

// ===== testbench/pmg_board.sv
// Board circuitry at the port-4 pins.
// Assumes undriven lines settle to the level the bench sets.
`timescale 1ns/1ps
module pmg_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext_level,
  output      logic [7:0] pin_in
);
  // Driven pins echo the port, others take the board pull
  assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule : pmg_board

// ===== testbench/port4_pin_mux_gpio_tb.sv
// Self-checking bench for the port-4 pin mux.
// Assumes the checker is bound and the board model closes the pins.
`timescale 1ns/1ps
`include "pmg_regs.svh"
module port4_pin_mux_gpio_tb;
  import pmg_pkg::*;
  localparam logic [17:0] A_DIR = {`PMG_IDX_DIR, 2'h0};
  localparam logic [17:0] A_DAT = {`PMG_IDX_DATA, 2'h0};
  localparam logic [17:0] A_CTL = {`PMG_IDX_CTRL, 2'h0};
  localparam logic [17:0] A_STA = {`PMG_IDX_STAT, 2'h0};
  localparam logic [17:0] A_BAD = 18'h00100;
  logic            sys_clk;
  logic            reset;
  logic [17:0]     awaddr, araddr;
  logic [31:0]     wdata, rdata, r;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, lvl6;
  logic [1:0]      bresp, rresp, mode_pins;
  logic            hw_standby;
  pmg_periph_out_t periph_out;
  pmg_periph_in_t  periph_in;
  logic [7:0]      pin_in, pin_out, pin_oe_n, ext_level;
  logic [31:0]     rq[$];
  int              n_fail = 0;
  int              samples_checked = 0;
  int              cyc = 0;
  ////////////////////////////////////////
  pmg_port4 dut_u (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode_pins(mode_pins), .hw_standby(hw_standby), .periph_out(periph_out),
    .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
  );
  pmg_board board_u (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    logic       done;
    logic [1:0] er;
    done = 1'b0;
    er = (a == A_BAD) ? `PMG_RESP_SLVERR : `PMG_RESP_OKAY;
    if (!w) rq.push_back(d);
    @(posedge sys_clk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= w;
    wvalid  <= w;
    bready  <= w;
    arvalid <= !w;
    rready  <= !w;
    while (!done) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if ((bvalid && bready) || (rvalid && rready)) begin
        chk(32'(bready ? bresp : rresp), 32'(er));
        bready <= 1'b0;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : xfer
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic pins(input logic [7:0] eoe, input logic [7:0] eout, input logic [7:0] m);
    chk(32'(pin_oe_n), 32'(eoe));
    chk(32'(pin_out & m), 32'(eout & m));
  endtask : pins
  task automatic rst(input logic [1:0] m);
    mode_pins <= m;
    reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
  endtask : rst
  ////////////////////////////////////////
  // Read results against the noted expectations
  always @(posedge sys_clk) begin
    cyc++;
    if (rvalid && rready) chk(rdata, rq.pop_front());
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    {reset, awvalid, wvalid, bready, arvalid, rready, hw_standby} = 7'h40;
    {awaddr, araddr, wdata, ext_level} = '0;
    mode_pins = 2'h3;
    periph_out = '0;
    r = $urandom(32'h792B);
    rst(2'h3);
    r = $urandom;
    ext_level <= r[7:0];
    settle(5);
    pins(8'hFF, 8'h00, 8'h00);
    xfer(0, A_DIR, 32'hFF);
    xfer(0, A_DAT, 32'(ext_level));
    for (int k = 0; k < 6; k++) begin
      r = $urandom;
      xfer(1, A_DIR, 32'(r[7:0]));
      xfer(1, A_DAT, 32'(r[15:8]));
      ext_level <= r[23:16];
      periph_out <= pmg_periph_out_t'(r[31:23]);
      settle(5);
      pins(~r[7:0], r[15:8], r[7:0] & 8'hBF);
      lvl6 = r[6] ? periph_out.clock_out : ext_level[6];
      xfer(0, A_DAT, 32'((r[7:0] & r[15:8] | ~r[7:0] & ext_level) & 8'hBF | {lvl6, 6'h0}));
    end
    xfer(1, A_DIR, 32'h10);
    xfer(1, A_DAT, 32'h10);
    xfer(1, A_CTL, 32'h4);
    settle(2);
    pins(8'h6F, {periph_out.clamp_out, 2'h0, periph_out.hsync_out, 4'h0}, 8'h90);
    xfer(1, A_CTL, 32'h550);
    settle(2);
    pins(8'h6F, {periph_out.timer_x_out, 2'h0, periph_out.timer1_out, 4'h0}, 8'h90);
    xfer(1, A_CTL, 32'h55C);
    settle(2);
    pins(8'hEF, 8'h10, 8'h90);
    xfer(0, A_DAT, 32'(8'h10 | ext_level & 8'hEF));
    xfer(1, A_DIR, 32'hB8);
    xfer(1, A_CTL, 32'h3);
    settle(4);
    pins(8'h47, {periph_out.gate_a20_out, 1'b0, periph_out.host_irq_twelve,
      periph_out.host_irq_one, periph_out.host_irq_eleven, 3'h0}, 8'hB8);
    chk(32'(periph_in.host_chip_select_n), 32'(ext_level[6]));
    xfer(1, A_DIR, 32'h0);
    ext_level <= 8'hFF;
    xfer(1, A_CTL, 32'h77000);
    settle(5);
    chk(32'(periph_in), 32'h7F);
    xfer(1, A_CTL, 32'h0);
    settle(2);
    chk(32'(periph_in), 32'h2D);
    xfer(1, A_BAD, 32'h5A);
    xfer(0, A_BAD, 32'h0);
    xfer(1, A_DIR, 32'hFF);
    xfer(1, A_DAT, 32'h55);
    hw_standby <= 1'b1;
    settle(6);
    hw_standby <= 1'b0;
    settle(4);
    pins(8'hFF, 8'h00, 8'h00);
    xfer(1, A_DIR, 32'hFF);
    settle(2);
    pins(8'h00, 8'h00, 8'hBF);
    rst(2'h2);
    settle(2);
    pins(8'hBF, {1'b0, periph_out.clock_out, 6'h0}, 8'h40);
    xfer(1, A_DIR, 32'h20);
    xfer(1, A_DAT, 32'h20);
    xfer(1, A_CTL, 32'h1);
    settle(2);
    pins(8'h9F, 8'h20, 8'h20);
    xfer(0, A_STA, {16'h0000, 8'hBF | {periph_out.clock_out, 6'h00}, 8'h02});
    xfer(0, A_DIR, 32'hFF);
    end_of_test();
  end
endmodule : port4_pin_mux_gpio_tb
